// ---- logic/sci_tx_params.svh ----
`ifndef SCI_TX_PARAMS_SVH
`define SCI_TX_PARAMS_SVH

// Register byte offsets
`define OFS_CONTROL_ONE   8'h00
`define OFS_CONTROL_TWO   8'h04
`define OFS_STATUS_ONE    8'h08
`define OFS_DATA_HIGH     8'h0C
`define OFS_DATA_LOW      8'h10
`define OFS_BAUD_DIV      8'h14
`define OFS_PIN_OUT       8'h18
`define OFS_PIN_DIR       8'h1C

// control_one fields
`define C1_WORD_LONG      0
`define C1_PARITY_ON      1
`define C1_PARITY_ODD     2
// control_two fields
`define C2_TX_ON          0
`define C2_SEND_BREAK     1
`define C2_TX_EMPTY_IRQ   2
// status_one fields
`define S1_TX_BUF_EMPTY   0
`define S1_TX_DONE        1
// Port bit that carries the transmit pin
`define PIN_TX_BIT        1

// Reset values
`define RST_BAUD_DIV      16'h0001
`define RST_BYTE          8'h00

// Bit timing in baud ticks
`define SUB_LAST          4'hF
`define STAGE_SUB         4'h8

// Frame lengths in bits
`define LEN_SHORT         4'hA
`define LEN_LONG          4'hB
`define LEN_ONE           4'h1

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- logic/sci_tx_pkg.sv ----
package sci_tx_pkg;

  // Shift engine state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } tx_state_t;

endpackage : sci_tx_pkg

// ---- logic/baud_tick_gen.sv ----
`timescale 1ns/1ns
`include "sci_tx_params.svh"

module baud_tick_gen #(
  parameter int DIV_W = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt;
  wire  logic       at_end;

  // A divisor of zero behaves as one, so the tick never stops
  assign at_end = ({1'b0, cnt} + {{DIV_W{1'b0}}, 1'b1}) >= {1'b0, divisor};

  // Free-running divider, one tick per wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (at_end) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule : baud_tick_gen

// ---- logic/async_serial_transmitter.sv ----
// What this block, its software and receivers do
// (R1) Ten-bit frames short, eleven-bit frames long
// (R2) Ninth bit comes from tx_ninth_bit
// (R3) One start bit, one stop bit
// (R4) Parity goes into top data bit
// (R5) tx_on rising loads preamble of ones
// (R6) After preamble, data framed start/stop shifts
// (R7) Each transfer sets buffer empty, may interrupt
// (R8) Transfer happens 9/16 into stop bit
// (R9) Status read then data write loads word
// (R10) Pin idles high between frames
// (R11) tx_on low when idle releases pin
// (R12) tx_on low mid-frame: finish, then release
// (R13) Software waits for empty before disabling
// (R14) Off-on toggle mid-frame queues idle frame
// (R15) Toggle must land before stop bit
// (R16) Message gap: wait, toggle, then write
// (R17) send_break repeats all-zero frames
// (R18) After break, at least one one
// (R19) Receivers see zero frames as break
// (R20) Idle frame is all ones, word length
// (R21) Port registers hold pin after release
// (R22) Sixteen baud ticks per bit
// (R23) tx_ninth_bit kept after transmission
// (R24) Data shifts least significant bit first
// (R25) tx_done low while anything shifts
`timescale 1ns/1ns
`include "sci_tx_params.svh"

module async_serial_transmitter
  import sci_tx_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             tx_pin_o,
  output logic             tx_pin_oe,
  output logic             tx_irq
);

  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
    $error("DIV_W must lie between 2 and 16");
  end

  function automatic logic reg_mapped(input logic [7:0] a);
    return a == `OFS_CONTROL_ONE || a == `OFS_CONTROL_TWO || a == `OFS_STATUS_ONE ||
           a == `OFS_DATA_HIGH || a == `OFS_DATA_LOW || a == `OFS_BAUD_DIV ||
           a == `OFS_PIN_OUT || a == `OFS_PIN_DIR;
  endfunction : reg_mapped

  function automatic logic [3:0] frame_len(input logic long_word);
    return long_word ? `LEN_LONG : `LEN_SHORT; // see R1
  endfunction : frame_len

  // Start bit at bit 0, data LSB first, stop bit(s) above
  function automatic logic [10:0] build_data(input logic       long_word,
                                             input logic       par_on,
                                             input logic       par_odd,
                                             input logic       ninth,
                                             input logic [7:0] low);
    logic [8:0] d;
    d = {ninth, low}; // see R2
    if (long_word) begin
      if (par_on) d[8] = (^d[7:0]) ^ par_odd; // see R4
      return {1'b1, d, 1'b0}; // see R3, R24
    end
    if (par_on) d[7] = (^d[6:0]) ^ par_odd; // see R4
    return {2'b11, d[7:0], 1'b0}; // see R3, R24
  endfunction : build_data

  // Software-visible state, plus the internal clear_armed flag
  logic [2:0]       control_one;
  logic             tx_on;
  logic             send_break;
  logic             tx_empty_irq_en;
  logic             tx_ninth_bit;
  logic [7:0]       data_low_reg;
  logic [DIV_W-1:0] baud_div;
  logic [7:0]       pin_out_reg;
  logic [7:0]       pin_dir_reg;
  logic             tx_buffer_empty;
  logic             tx_done;
  logic             clear_armed;

  // Bus holding registers
  logic [7:0]       aw_addr_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;

  // Shift engine
  tx_state_t        state;
  logic [10:0]      shreg;
  logic [3:0]       bits_left;
  logic [3:0]       sub;
  logic             staged;
  logic [10:0]      staged_frame;
  logic             pre_pend;
  logic             one_pend;
  wire  logic       tick;

  baud_tick_gen #(.DIV_W(DIV_W)) u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divisor (baud_div),
    .tick    (tick)
  );

  // Write and read decode
  wire logic        wr_fire  = !awready && !wready && !bvalid;
  wire logic        wr_lane  = wr_fire && w_strb_q[0];
  wire logic        wr_c1    = wr_lane && aw_addr_q == `OFS_CONTROL_ONE;
  wire logic        wr_c2    = wr_lane && aw_addr_q == `OFS_CONTROL_TWO;
  wire logic        wr_dh    = wr_lane && aw_addr_q == `OFS_DATA_HIGH;
  wire logic        wr_dl    = wr_lane && aw_addr_q == `OFS_DATA_LOW;
  wire logic        wr_div   = wr_lane && aw_addr_q == `OFS_BAUD_DIV;
  wire logic        wr_pout  = wr_lane && aw_addr_q == `OFS_PIN_OUT;
  wire logic        wr_pdir  = wr_lane && aw_addr_q == `OFS_PIN_DIR;
  wire logic        rd_fire  = arvalid && arready;
  wire logic        rd_stat  = rd_fire && araddr == `OFS_STATUS_ONE;
  wire logic        tx_on_up = wr_c2 && w_data_q[`C2_TX_ON] && !tx_on;
  wire logic [31:0] rd_word  =
      (araddr == `OFS_CONTROL_ONE) ? {29'h0, control_one} :
      (araddr == `OFS_CONTROL_TWO) ? {29'h0, tx_empty_irq_en, send_break, tx_on} :
      (araddr == `OFS_STATUS_ONE)  ? {30'h0, tx_done, tx_buffer_empty} :
      (araddr == `OFS_DATA_HIGH)   ? {31'h0, tx_ninth_bit} :
      (araddr == `OFS_DATA_LOW)    ? {24'h0, data_low_reg} :
      (araddr == `OFS_BAUD_DIV)    ? 32'(baud_div) :
      (araddr == `OFS_PIN_OUT)     ? {24'h0, pin_out_reg} :
      (araddr == `OFS_PIN_DIR)     ? {24'h0, pin_dir_reg} : 32'h0;

  // Frame sequencing decisions
  wire logic        busy      = state == ST_SHIFT;
  wire logic        last_bit  = busy && bits_left == `LEN_ONE;
  wire logic        frame_end = last_bit && tick && sub == `SUB_LAST;
  wire logic        one_need  = one_pend && !send_break;
  wire logic        data_ok   = tx_on && !pre_pend && !send_break && !one_pend &&
                                !tx_buffer_empty;
  wire logic        stage_now = last_bit && tick && sub == `STAGE_SUB && !staged &&
                                data_ok; // see R8
  wire logic        start_ok  = tx_on && (!busy || frame_end);
  wire logic        load_one  = start_ok && !staged && one_need;
  wire logic        load_pre  = start_ok && !staged && !one_need && pre_pend;
  wire logic        load_brk  = start_ok && !staged && !one_need && !pre_pend && send_break;
  wire logic        load_dat  = start_ok && (staged || (!one_need && !pre_pend &&
                                !send_break && !tx_buffer_empty));
  wire logic        load_any  = load_one || load_pre || load_brk || load_dat;
  wire logic        discard   = !tx_on && (!busy || frame_end);
  wire logic [10:0] built     = build_data(control_one[`C1_WORD_LONG],
                                           control_one[`C1_PARITY_ON],
                                           control_one[`C1_PARITY_ODD],
                                           tx_ninth_bit, data_low_reg);
  wire logic [10:0] load_frame =
      load_dat ? (staged ? staged_frame : built) :
      load_brk ? 11'h000 : 11'h7FF; // see R17, R20
  wire logic [3:0]  load_len  = load_one ? `LEN_ONE : frame_len(control_one[`C1_WORD_LONG]);

  // Write channel: address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= reg_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Read channel: one request at a time, answer one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `RESP_OKAY;
    end else if (rd_fire) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= reg_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Plain control registers; tx_ninth_bit only changes on a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_one     <= 3'h0;
      tx_on           <= 1'b0;
      send_break      <= 1'b0;
      tx_empty_irq_en <= 1'b0;
      tx_ninth_bit    <= 1'b0;
      data_low_reg    <= `RST_BYTE;
      baud_div        <= DIV_W'(`RST_BAUD_DIV);
      pin_out_reg     <= `RST_BYTE;
      pin_dir_reg     <= `RST_BYTE;
    end else begin
      if (wr_c1) control_one <= w_data_q[2:0];
      if (wr_c2) begin
        tx_on           <= w_data_q[`C2_TX_ON];
        send_break      <= w_data_q[`C2_SEND_BREAK];
        tx_empty_irq_en <= w_data_q[`C2_TX_EMPTY_IRQ];
      end
      if (wr_dh) tx_ninth_bit <= w_data_q[0]; // see R23
      if (wr_dl) data_low_reg <= w_data_q[7:0];
      if (wr_div) baud_div <= w_data_q[DIV_W-1:0];
      if (wr_pout) pin_out_reg <= w_data_q[7:0];
      if (wr_pdir) pin_dir_reg <= w_data_q[7:0];
    end
  end

  // Buffer flag: the data write clears it, a transfer or discard sets it and wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buffer_empty <= 1'b1;
      clear_armed     <= 1'b0;
    end else begin
      if (rd_stat && tx_buffer_empty) clear_armed <= 1'b1; // see R9
      if (wr_dl && clear_armed) begin
        tx_buffer_empty <= 1'b0; // see R9
        clear_armed     <= 1'b0;
      end
      if (stage_now || (load_dat && !staged)) tx_buffer_empty <= 1'b1; // see R7
      if (discard) tx_buffer_empty <= 1'b1; // see R12
    end
  end

  // Preamble and post-break requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_pend <= 1'b0;
      one_pend <= 1'b0;
    end else begin
      if (load_pre || (!tx_on && !busy)) pre_pend <= 1'b0;
      if (tx_on_up) pre_pend <= 1'b1; // see R5, R14
      if (load_one || (!tx_on && !busy)) one_pend <= 1'b0;
      if (load_brk) one_pend <= 1'b1; // see R18
    end
  end

  // Next word is framed early, in the stop bit of the frame on the line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      staged       <= 1'b0;
      staged_frame <= 11'h7FF;
    end else if (stage_now) begin
      staged       <= 1'b1; // see R8
      staged_frame <= built;
    end else if (load_dat || discard) begin
      staged       <= 1'b0;
    end
  end

  // Shift engine, one bit per sixteen baud ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_IDLE;
      shreg     <= 11'h7FF;
      bits_left <= 4'h0;
      sub       <= 4'h0;
    end else if (load_any) begin
      state     <= ST_SHIFT; // see R5, R6, R17
      shreg     <= load_frame;
      bits_left <= load_len;
      sub       <= 4'h0;
    end else if (frame_end) begin
      state     <= ST_IDLE; // see R12
    end else if (busy && tick) begin
      sub <= sub + 1'b1; // see R22
      if (sub == `SUB_LAST) begin
        shreg     <= {1'b1, shreg[10:1]}; // see R24
        bits_left <= bits_left - 1'b1;
      end
    end
  end

  // Pin drive and flags, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin_o  <= 1'b0;
      tx_pin_oe <= 1'b0;
      tx_done   <= 1'b1;
      tx_irq    <= 1'b0;
    end else begin
      tx_pin_o  <= busy ? shreg[0] : (tx_on | pin_out_reg[`PIN_TX_BIT]); // see R10, R11
      tx_pin_oe <= busy | tx_on | pin_dir_reg[`PIN_TX_BIT]; // see R11, R21
      tx_done   <= !busy && !load_any && tx_buffer_empty && !pre_pend; // see R25
      tx_irq    <= tx_buffer_empty && tx_empty_irq_en; // see R7
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_frame_len;
    load_dat |=> bits_left == frame_len(control_one[`C1_WORD_LONG]) && shreg[0] == 1'b0;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("data frame length wrong"); // see R1

  property p_preamble;
    load_pre |=> busy && shreg == 11'h7FF && bits_left == frame_len(control_one[0]);
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble not all ones"); // see R5

  property p_stop_bit;
    load_dat && !staged |=> shreg[bits_left - 1'b1] == 1'b1;
  endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("stop bit missing"); // see R6

  property p_stage_time;
    stage_now |-> sub == `STAGE_SUB && bits_left == `LEN_ONE && tick ##1 tx_buffer_empty;
  endproperty
  a_stage_time: assert property (p_stage_time) else $error("transfer off 9/16 point"); // see R8

  property p_idle_high;
    !busy && tx_on |=> tx_pin_o && tx_pin_oe;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle pin not high"); // see R10

  property p_release;
    !busy && !tx_on |=> tx_pin_oe == $past(pin_dir_reg[`PIN_TX_BIT]);
  endproperty
  a_release: assert property (p_release) else $error("pin not released"); // see R11

  property p_off_finish;
    frame_end && !tx_on |=> !busy && tx_buffer_empty && !staged;
  endproperty
  a_off_finish: assert property (p_off_finish) else $error("stop did not discard"); // see R12

  property p_break;
    load_brk |=> shreg == 11'h000 ##1 !(load_dat && $past(busy));
  endproperty
  a_break: assert property (p_break) else $error("break frame not zero"); // see R17

  property p_after_break;
    frame_end && one_pend && !send_break && tx_on |=> busy && shreg[0] && bits_left == `LEN_ONE;
  endproperty
  a_after_break: assert property (p_after_break) else $error("no one after break"); // see R18

  property p_bit_hold;
    busy && tick && sub != `SUB_LAST && !load_any |=> $stable(shreg) && $stable(bits_left);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit moved early"); // see R22

  property p_done_low;
    busy |=> !tx_done;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done while shifting"); // see R25

endmodule : async_serial_transmitter

// ---- dv/line_rx_model.sv ----
`timescale 1ns/1ns

// Far-end receiver on the line; bit time is 16 clocks with baud_div 1
module line_rx_model (
  input  wire logic        aclk,
  input  wire logic        line,
  input  wire logic        long_mode,
  output logic [10:0]      rx_bits,
  output logic [15:0]      rx_count,
  output logic [31:0]      fall_ns,
  output logic             rx_break
);
  logic last;
  int   i;

  // Falling edge after a high marks a start bit; sample near mid-bit
  initial begin
    rx_bits = 11'h000;
    rx_count = 16'h0000;
    fall_ns = 32'h0;
    rx_break = 1'b0;
    last = 1'b1;
    forever begin
      @(posedge aclk);
      if (last === 1'b1 && line === 1'b0) begin
        fall_ns = 32'($time);
        repeat (7) @(posedge aclk);
        for (i = 0; i < (long_mode ? 11 : 10); i++) begin
          if (i > 0) repeat (16) @(posedge aclk);
          rx_bits[i] = line;
        end
        if (!long_mode) rx_bits[10] = 1'b0;
        // All-zero frame with a zero stop place reads as a break
        rx_break = (rx_bits === 11'h000);
        rx_count = rx_count + 16'h0001;
      end
      last = line;
    end
  end
endmodule : line_rx_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`include "sci_tx_params.svh"

module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, long_mode;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, f1, fall_ns;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, tx_pin_o, tx_pin_oe, tx_irq;
  logic [1:0]  bresp, rresp, resp;
  logic [10:0] rx_bits;
  logic [15:0] rx_count;
  logic        rx_break;
  int          err_total, cmp_count, p, n;
  wire         line = tx_pin_oe ? tx_pin_o : 1'b1; // Pull-up while released

  async_serial_transmitter i_async_serial_transmitter (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .tx_irq(tx_irq));

  line_rx_model i_line_rx_model (
    .aclk(aclk), .line(line), .long_mode(long_mode), .rx_bits(rx_bits),
    .rx_count(rx_count), .fall_ns(fall_ns), .rx_break(rx_break));

  // 250 MHz clock
  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && k < 100);
    resp = bresp;
    bready <= 1'b0;
    if (k >= 100) err_total++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && k < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (k >= 100) err_total++;
  endtask : axi_rd

  // Status read that sees the buffer empty, then the low byte
  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[`S1_TX_BUF_EMPTY] !== 1'b1 && k < 200) begin
      axi_rd(`OFS_STATUS_ONE, rd, resp);
      k++;
    end
    if (k >= 200) err_total++;
    axi_wr(`OFS_DATA_LOW, {24'h0, b});
  endtask : send

  // Bounded waits on the far-end receiver
  task automatic wait_rx(input logic [15:0] c);
    int k;
    k = 0;
    while (rx_count < c && k < 2000) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 2000) err_total++;
  endtask : wait_rx

  task automatic wait_fall();
    int k;
    k = 0;
    while (fall_ns == f1 && k < 400) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 400) err_total++;
  endtask : wait_fall

  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // Hang guard, far beyond the few thousand cycles the tests take
  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  // Main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, long_mode} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`OFS_STATUS_ONE, rd, resp);
    chk(rd, 32'h3);
    chk(tx_pin_oe, 1'b0);
    axi_rd(8'h20, rd, resp);
    chk(resp, `RESP_SLVERR);
    // Unmapped write answers with an error and touches nothing
    axi_wr(8'h20, 32'h0);
    chk(resp, `RESP_SLVERR);
    // Port registers own the pin while the transmitter is off
    axi_wr(`OFS_PIN_OUT, 32'h2);
    axi_wr(`OFS_PIN_DIR, 32'h2);
    repeat (2) @(posedge aclk);
    chk({tx_pin_oe, tx_pin_o}, 2'b11);
    // Enable: preamble of ten ones, then the first frame
    axi_wr(`OFS_CONTROL_TWO, 32'h5);
    f1 = 32'($time);
    send(8'hA5);
    wait_rx(16'h1);
    chk(rx_bits, {2'b01, 8'hA5, 1'b0});
    n = (fall_ns - f1) / 4;
    chk(n >= 155 && n <= 170, 1'b1);
    repeat (16) @(posedge aclk);
    chk({tx_pin_oe, line, tx_irq}, 3'b111);
    // Back to back frames leave no idle bit between them
    send(8'h5A);
    axi_rd(`OFS_STATUS_ONE, rd, resp);
    chk(rd[`S1_TX_DONE], 1'b0);
    send(8'h0F);
    wait_rx(16'h2);
    f1 = fall_ns;
    wait_rx(16'h3);
    chk(rx_bits, {2'b01, 8'h0F, 1'b0});
    n = (fall_ns - f1) / 4;
    chk(n >= 158 && n <= 163, 1'b1);
    // Even then odd parity in the top data bit
    for (p = 0; p < 2; p++) begin
      axi_wr(`OFS_CONTROL_ONE, 32'h2 | (p << 2));
      send(8'h13);
      wait_rx(16'(4 + p));
      chk(rx_bits[8:1], {~p[0], 7'h13});
    end
    // Long words: ninth bit kept for the next frame
    axi_wr(`OFS_CONTROL_ONE, 32'h1);
    long_mode <= 1'b1;
    axi_wr(`OFS_DATA_HIGH, 32'h1);
    send(8'h3C);
    send(8'hC3);
    wait_rx(16'h6);
    chk(rx_bits, {2'b11, 8'h3C, 1'b0});
    wait_rx(16'h7);
    chk(rx_bits, {2'b11, 8'hC3, 1'b0});
    // Off-on toggle mid-frame queues one eleven-bit idle frame
    f1 = fall_ns;
    send(8'h81);
    wait_fall();
    axi_wr(`OFS_CONTROL_TWO, 32'h4);
    axi_wr(`OFS_CONTROL_TWO, 32'h5);
    f1 = fall_ns;
    send(8'h7E);
    wait_rx(16'h9);
    chk(rx_bits, {2'b11, 8'h7E, 1'b0});
    n = (fall_ns - f1) / 4;
    chk(n >= 350 && n <= 355, 1'b1);
    // Break frames, then a high before the next start
    axi_wr(`OFS_CONTROL_TWO, 32'h7);
    wait_rx(16'hA);
    chk(rx_break, 1'b1);
    axi_wr(`OFS_CONTROL_TWO, 32'h5);
    n = 0;
    while (line !== 1'b1 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    chk(line, 1'b1);
    // Disable mid-frame: frame completes, pending byte dropped
    axi_wr(`OFS_PIN_OUT, 32'h0);
    f1 = fall_ns;
    send(8'h66);
    wait_fall();
    send(8'h99);
    axi_wr(`OFS_CONTROL_TWO, 32'h4);
    wait_rx(16'hB);
    chk(rx_bits, {2'b11, 8'h66, 1'b0});
    repeat (16) @(posedge aclk);
    chk({tx_pin_oe, tx_pin_o}, 2'b10);
    axi_rd(`OFS_STATUS_ONE, rd, resp);
    chk(rd[1:0], 2'b11);
    end_sim();
  end
endmodule : tb_top
